// ===== dv/mcb_bank_assertions.sv
/* Assertion checker for the meter configuration bank.
 * Assumes it is bound to mcb_bank and sees only its ports. */
module mcb_bank_chk (
	input wire logic sys_clk_in, // Clock.
	input wire logic arst_n_in, // Reset.
	input wire logic wake_in, // Wake.
	input mcb_pkg::mcb_bus_req_t bus_in, // Access.
	input wire logic mux_sync_in, // Sync.
	input wire logic interval_end_in, // Interval end.
	input wire logic [7:0] rdata_out, // Read data.
	input wire logic conv_en_out, // Converter.
	input wire logic batt_load_out, // Load.
	input wire logic batt_route_out, // Route.
	input wire logic [17:0] boot_end_out, // Boot end.
	input wire logic [14:0] prog_start_out, // Program start.
	input wire logic eng_en_out, // Engine on.
	input wire logic eng_clk_en_out, // Engine clock.
	input wire logic chop_out, // Chop.
	input wire logic alt_frame_out, // Alt frame.
	input wire logic ichop_a_out, // Chop A.
	input wire logic ichop_b_out // Chop B.
);
	import mcb_pkg::*;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	////////////////////////////////////////////////////////////////
	// Read-back of undefined and unmapped places.
	undef_zero_a: assert property (bus_in.rd && bus_in.addr == 16'h2005 |=>
		rdata_out[7:4] == 4'h0 && rdata_out[2:0] == 3'h0) else $error("undefined bits set");
	unmap_zero_a: assert property (bus_in.rd && bus_in.addr == 16'h2001 |=>
		rdata_out == 8'h00) else $error("unmapped read not zero");
	// Derived outputs.
	batt_pair_a: assert property (bus_in.wr && bus_in.addr == 16'h2020 && !wake_in |-> ##2
		batt_load_out == $past(bus_in.wdata[6], 2) && batt_route_out == batt_load_out)
		else $error("load and route wrong");
	boot_unit_a: assert property (bus_in.wr && bus_in.addr == 16'h20a7 && !wake_in |-> ##2
		boot_end_out == {$past(bus_in.wdata, 2), 10'h000}) else $error("boot end wrong");
	prog_unit_a: assert property (bus_in.wr && bus_in.addr == 16'h20a8 && !wake_in |-> ##2
		prog_start_out == {$past(bus_in.wdata[4:0], 2), 10'h000})
		else $error("program start wrong");
	conv_follow_a: assert property (bus_in.wr && bus_in.addr == 16'h2005 && !wake_in |->
		##2 conv_en_out == $past(bus_in.wdata[3], 2)) else $error("converter enable wrong");
	ichop_gate_a: assert property (bus_in.wr && bus_in.addr == 16'h20ab &&
		!bus_in.wdata[0] |-> ##2 !ichop_a_out && !ichop_b_out) else $error("chop without master");
	wake_boot_a: assert property (wake_in |-> ##2 boot_end_out == 18'h00400)
		else $error("wake boot end wrong");
	// Chop timing and engine clock spacing.
	chop_edge_a: assert property ($changed(chop_out) |->
		$past(mux_sync_in) && !$past(mux_sync_in, 2)) else $error("chop off sync edge");
	alt_cause_a: assert property (alt_frame_out |-> $past(interval_end_in) &&
		$past(mux_sync_in) && !$past(mux_sync_in, 2)) else $error("alt frame uncaused");
	eng_gap_a: assert property (eng_clk_en_out |=> !eng_clk_en_out)
		else $error("engine pulses adjacent");
endmodule : mcb_bank_chk

bind mcb_bank mcb_bank_chk u_chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
	.wake_in(wake_in), .bus_in(bus_in), .mux_sync_in(mux_sync_in),
	.interval_end_in(interval_end_in), .rdata_out(rdata_out), .conv_en_out(conv_en_out),
	.batt_load_out(batt_load_out), .batt_route_out(batt_route_out),
	.boot_end_out(boot_end_out), .prog_start_out(prog_start_out), .eng_en_out(eng_en_out),
	.eng_clk_en_out(eng_clk_en_out), .chop_out(chop_out), .alt_frame_out(alt_frame_out),
	.ichop_a_out(ichop_a_out), .ichop_b_out(ichop_b_out));

// ===== dv/testbench.sv
/* Self-checking bench for the meter configuration bank.
 * Assumes the design and the checker are compiled before it. */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mcb_pkg::*;
	logic sys_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic wake_in = 1'b0;
	mcb_bus_req_t bus_in = '0;
	logic mux_sync_in = 1'b0;
	logic interval_end_in = 1'b0;
	logic [7:0] rdata_out;
	logic [17:0] boot_end_out;
	logic [14:0] prog_start_out;
	logic conv_en_out, batt_load_out, batt_route_out, eng_en_out, eng_clk_en_out;
	logic chop_out, alt_frame_out, ichop_a_out, ichop_b_out;
	logic [15:0] ad [8] = '{16'h2000, 16'h2002, 16'h2005, 16'h2020,
		16'h20a7, 16'h20a8, 16'h20ab, 16'h20ac};
	logic [7:0] mk [8] = '{8'h18, 8'h30, 8'h08, 8'h40, 8'hff, 8'h1f, 8'h01, 8'h11};
	logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h1f, 8'h00, 8'h00};
	logic [31:0] rs = 32'd50;
	logic [7:0] v;
	int n_fail = 0;
	int n_tests = 0;
	int n_alt = 0;
	int cnt;
	mcb_bank u_mcb_bank (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .wake_in(wake_in),
		.bus_in(bus_in), .mux_sync_in(mux_sync_in), .interval_end_in(interval_end_in),
		.rdata_out(rdata_out), .conv_en_out(conv_en_out), .batt_load_out(batt_load_out),
		.batt_route_out(batt_route_out), .boot_end_out(boot_end_out),
		.prog_start_out(prog_start_out), .eng_en_out(eng_en_out),
		.eng_clk_en_out(eng_clk_en_out), .chop_out(chop_out), .alt_frame_out(alt_frame_out),
		.ichop_a_out(ichop_a_out), .ichop_b_out(ichop_b_out));
	////////////////////////////////////////////////////////////////
	// Clock of 40 ns and a count of alternative frame pulses.
	initial begin
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	always @(negedge sys_clk_in) begin
		if (alt_frame_out === 1'b1) n_alt++;
	end
	// Pseudo-random step.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Write holds an extra cycle so derived outputs have settled.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk_in) bus_in = '{1'b1, 1'b0, a, d};
		@(negedge sys_clk_in) bus_in.wr = 1'b0;
		@(negedge sys_clk_in);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(negedge sys_clk_in) bus_in = '{1'b0, 1'b1, a, 8'h00};
		@(negedge sys_clk_in) bus_in.rd = 1'b0;
		v = rdata_out;
	endtask : rd
	task automatic sync(input logic e);
		@(negedge sys_clk_in) {mux_sync_in, interval_end_in} = {1'b1, e};
		@(negedge sys_clk_in) {mux_sync_in, interval_end_in} = 2'b00;
		repeat (2) @(negedge sys_clk_in);
	endtask : sync
	// Counts engine clock pulses over 50 cycles.
	task automatic eng(input logic [7:0] d, input int n);
		wr(16'h2000, d);
		repeat (5) @(negedge sys_clk_in);
		cnt = 0;
		repeat (50) @(negedge sys_clk_in) cnt += int'(eng_clk_en_out === 1'b1);
		chk(cnt[17:0], n[17:0]);
	endtask : eng
	task automatic print_verdict();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (12) @(negedge sys_clk_in);
		arst_n_in = 1'b1;
		for (int k = 0; k < 8; k++) begin
			rd(ad[k]);
			chk(v, ex[k]);
		end
		chk(prog_start_out, 18'h07c00);
		// Chop modes 11 and 00 with and without interval end, then 01 and 10 without it.
		wr(16'h2002, 8'h30);
		sync(1'b0);
		chk(chop_out, 1'b1);
		sync(1'b1);
		chk({chop_out, n_alt[0]}, 2'b00);
		wr(16'h2002, 8'h00);
		sync(1'b0);
		chk(chop_out, 1'b1);
		sync(1'b1);
		chk({chop_out, n_alt[0]}, 2'b11);
		wr(16'h2002, 8'h10);
		chk(chop_out, 1'b1);
		sync(1'b0);
		chk(chop_out, 1'b0);
		wr(16'h2002, 8'h20);
		sync(1'b0);
		chk(chop_out, 1'b1);
		ex[1] = 8'h20;
		eng(8'h18, 20);
		eng(8'h10, 10);
		eng(8'h08, 0);
		ex[0] = 8'h08;
		// Random writes, read-back and derived outputs.
		for (int i = 0; i < 60; i++) begin
			rs = xs(rs);
			wr(ad[rs[2:0]], rs[15:8]);
			ex[rs[2:0]] = rs[15:8] & mk[rs[2:0]];
			rd(ad[rs[2:0]]);
			chk(v, ex[rs[2:0]]);
			chk(conv_en_out, ex[2][3]);
			chk({batt_load_out, batt_route_out}, {2{ex[3][6]}});
			chk(boot_end_out, {ex[4], 10'h0});
			chk(prog_start_out, {ex[5][4:0], 10'h0});
			chk({ichop_a_out, ichop_b_out}, {2{ex[6][0]}} & {ex[7][0], ex[7][4]});
			chk(eng_en_out, ex[0][4]);
		end
		wr(16'h2001, 8'hff);
		rd(16'h2001);
		chk(v, 8'h00);
		// Wake restores fields but keeps the battery bit.
		wr(16'h20a7, 8'h55);
		wr(16'h2020, 8'h40);
		// A store to the boot size that races the wake pulse loses to it.
		@(negedge sys_clk_in) begin
			wake_in = 1'b1;
			bus_in = '{1'b1, 1'b0, 16'h20a7, 8'h55};
		end
		@(negedge sys_clk_in) begin
			wake_in = 1'b0;
			bus_in.wr = 1'b0;
		end
		rd(16'h20a7);
		chk(v, 8'h01);
		chk(prog_start_out, 18'h07c00);
		chk({conv_en_out, eng_en_out, ichop_a_out, ichop_b_out}, 4'h0);
		rd(16'h2020);
		chk(v, 8'h40);
		print_verdict();
	end
endmodule : testbench

// ===== rtl/mcb_bank.sv
/*
 * Meter configuration bank: byte registers written and read by the
 * processor, chop sequencing, engine clock enable and derived addresses.
 * Assumes the processor, the multiplexer sync, the interval marker and
 * the wake pulse all come from logic on sys_clk_in, so none of them is
 * synchronised here. Every output is registered: a field written by the
 * processor reaches the outputs one cycle after its write edge, the chop mode at the next sync rising edge.
 */
// Summary of operation
// - Write-only bits read back as zero.
// - Reset loads reset values, wake loads wake values, undefined ones keep.
// - The converter enable switches converter and reference on, off removes bias.
// - Battery measure enable loads the battery and routes it to the converter.
// - The boot region ends at the boot size field times 1024.
// - The engine program starts at the five-bit base field times 1024.
// - The engine runs at 10 MHz when selected, else 5 MHz, gated by its enable.
// - Bandgap chop changes only on a sync rising edge; 01 positive, 10 reversed.
// - Code 00 toggles except at interval end and inserts an alternative frame.
// - A current channel chops only when its bit and the master bit are set.
`include "mcb_cfg.svh"

module mcb_bank #(
	parameter int SYS_CLK_KHZ = `MCB_SYS_CLK_KHZ, // System clock rate in kHz.
	parameter int ENG_FAST_KHZ = `MCB_ENG_FAST_KHZ, // Engine rate with select set.
	parameter int ENG_SLOW_KHZ = `MCB_ENG_SLOW_KHZ // Engine rate with select clear.
) (
	input wire logic sys_clk_in, // System clock, 25 MHz.
	input wire logic arst_n_in, // Asynchronous reset, active low.
	input wire logic wake_in, // Wake pulse from power control.
	input mcb_pkg::mcb_bus_req_t bus_in, // Processor access.
	input wire logic mux_sync_in, // Multiplexer frame sync.
	input wire logic interval_end_in, // Accumulation interval ends.
	output logic [7:0] rdata_out, // Read data.
	output logic conv_en_out, // Converter and reference on.
	output logic batt_load_out, // Battery load applied.
	output logic batt_route_out, // Battery routed to converter.
	output logic [17:0] boot_end_out, // Boot region end address.
	output logic [14:0] prog_start_out, // Engine program start address.
	output logic eng_en_out, // Engine enabled.
	output logic eng_clk_en_out, // Engine clock enable pulse.
	output logic chop_out, // Bandgap chop, 1 means reversed.
	output logic alt_frame_out, // Alternative frame request pulse.
	output logic ichop_a_out, // Current channel A chop active.
	output logic ichop_b_out // Current channel B chop active.
);
	import mcb_pkg::*;

	// The engine accumulator never holds more than the system rate plus the
	// fast rate, which fits in 16 bits for the rates this block is built for.
	localparam logic [15:0] SYS_KHZ = 16'(SYS_CLK_KHZ);
	localparam logic [15:0] FAST_KHZ = 16'(ENG_FAST_KHZ);
	localparam logic [15:0] SLOW_KHZ = 16'(ENG_SLOW_KHZ);

	////////////////////////////////////////////////////////////////////
	// Register fields. Each byte location holds only the bits it defines.

	mcb_fields_t fld_ff;
	mcb_fields_t nxt_fld;
	mcb_fields_t wake_fld;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] rd_byte;

	// Reset image of the fields. It is a constant so that the asynchronous
	// reset branch loads nothing but constants.
	localparam mcb_fields_t RST_FLD = '{
		eng_clksel: `MCB_RST_BIT,
		eng_en: `MCB_RST_BIT,
		bgchop: mcb_chop_mode_t'(`MCB_RST_BGCHOP),
		conv_en: `MCB_RST_BIT,
		batt_en: `MCB_RST_BIT,
		boot_size: `MCB_RST_BOOT,
		prog_base: `MCB_RST_PROG,
		imaster: `MCB_RST_BIT,
		ichan_a: `MCB_RST_BIT,
		ichan_b: `MCB_RST_BIT
	};

	// Wake image of the fields. The battery measure bit has no defined wake
	// value, so it keeps what software last wrote; a wake during a battery
	// reading leaves the load applied until software clears the bit.
	always_comb begin
		wake_fld = fld_ff;
		wake_fld.eng_clksel = `MCB_WAKE_BIT;
		wake_fld.eng_en = `MCB_WAKE_BIT;
		wake_fld.bgchop = mcb_chop_mode_t'(`MCB_WAKE_BGCHOP);
		wake_fld.conv_en = `MCB_WAKE_BIT;
		wake_fld.boot_size = `MCB_WAKE_BOOT;
		wake_fld.prog_base = `MCB_WAKE_PROG;
		wake_fld.imaster = `MCB_WAKE_BIT;
		wake_fld.ichan_a = `MCB_WAKE_BIT;
		wake_fld.ichan_b = `MCB_WAKE_BIT;
	end

	// Byte writes touch only the defined bits of the addressed byte. Wake wins
	// over a write in the same cycle, so the wake image is never partly
	// overwritten by a store that raced it.
	always_comb begin
		nxt_fld = fld_ff;
		if (wake_in) begin
			nxt_fld = wake_fld;
		end else if (bus_in.wr) begin
			case (bus_in.addr)
				`MCB_ADDR_ENGINE: begin
					nxt_fld.eng_clksel = bus_in.wdata[`MCB_BIT_ENG_CLKSEL];
					nxt_fld.eng_en = bus_in.wdata[`MCB_BIT_ENG_EN];
				end
				`MCB_ADDR_BGCHOP: begin
					nxt_fld.bgchop = mcb_chop_mode_t'(
						bus_in.wdata[`MCB_BIT_BGCHOP_LO +: 2]);
				end
				`MCB_ADDR_CONV: begin
					nxt_fld.conv_en = bus_in.wdata[`MCB_BIT_CONV_EN];
				end
				`MCB_ADDR_BATT: begin
					nxt_fld.batt_en = bus_in.wdata[`MCB_BIT_BATT_EN];
				end
				`MCB_ADDR_BOOT: begin
					nxt_fld.boot_size = bus_in.wdata;
				end
				`MCB_ADDR_PROG: begin
					nxt_fld.prog_base = bus_in.wdata[4:0];
				end
				`MCB_ADDR_IMASTER: begin
					nxt_fld.imaster = bus_in.wdata[`MCB_BIT_IMASTER];
				end
				`MCB_ADDR_ICHAN: begin
					nxt_fld.ichan_a = bus_in.wdata[`MCB_BIT_ICHAN_A];
					nxt_fld.ichan_b = bus_in.wdata[`MCB_BIT_ICHAN_B];
				end
				default: begin
					nxt_fld = fld_ff;
				end
			endcase
		end
	end

	// Read multiplexer: undefined bits and unmapped bytes read zero. The
	// result is registered and held until the next read strobe; a read in the
	// same cycle as a write to that byte returns the old value.
	always_comb begin
		rd_byte = 8'h00;
		case (bus_in.addr)
			`MCB_ADDR_ENGINE: begin
				rd_byte[`MCB_BIT_ENG_CLKSEL] = fld_ff.eng_clksel;
				rd_byte[`MCB_BIT_ENG_EN] = fld_ff.eng_en;
			end
			`MCB_ADDR_BGCHOP: begin
				rd_byte[`MCB_BIT_BGCHOP_LO +: 2] = fld_ff.bgchop;
			end
			`MCB_ADDR_CONV: begin
				rd_byte[`MCB_BIT_CONV_EN] = fld_ff.conv_en;
			end
			`MCB_ADDR_BATT: begin
				rd_byte[`MCB_BIT_BATT_EN] = fld_ff.batt_en;
			end
			`MCB_ADDR_BOOT: begin
				rd_byte = fld_ff.boot_size;
			end
			`MCB_ADDR_PROG: begin
				rd_byte[4:0] = fld_ff.prog_base;
			end
			`MCB_ADDR_IMASTER: begin
				rd_byte[`MCB_BIT_IMASTER] = fld_ff.imaster;
			end
			`MCB_ADDR_ICHAN: begin
				rd_byte[`MCB_BIT_ICHAN_A] = fld_ff.ichan_a;
				rd_byte[`MCB_BIT_ICHAN_B] = fld_ff.ichan_b;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
		// No bit of this bank is write-only, so the mask is zero; it stays in
		// the path so that a write-only bit added later only needs a new mask.
		nxt_rdata = rdata_ff;
		if (bus_in.rd) begin
			nxt_rdata = rd_byte & ~`MCB_WO_MASK;
		end
	end

	// Field and read data registers. Only reset, wake and processor writes
	// change the fields, so their contents survive every change between the
	// battery modes that keep this bank powered.
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fld_ff <= RST_FLD;
			rdata_ff <= 8'h00;
		end else begin
			fld_ff <= nxt_fld;
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bandgap chop sequencing on the multiplexer sync.

	logic sync_d_ff;
	logic nxt_sync_d;
	logic chop_ff;
	logic nxt_chop;
	logic alt_ff;
	logic nxt_alt;
	logic sync_rise;

	// Chop moves only on a sync rising edge. The sync already runs on
	// sys_clk_in; a sync from another clock would need synchronising ahead of
	// this edge detector, which resets to the idle low level of the sync so
	// that no false edge follows reset.
	always_comb begin
		nxt_sync_d = mux_sync_in;
		sync_rise = mux_sync_in & ~sync_d_ff;
		nxt_chop = chop_ff;
		nxt_alt = 1'h0;
		if (sync_rise) begin
			case (fld_ff.bgchop)
				MCB_CHOP_POSITIVE: begin
					nxt_chop = 1'h0;
				end
				MCB_CHOP_REVERSED: begin
					nxt_chop = 1'h1;
				end
				MCB_CHOP_TOGGLE_ALT: begin
					// The edge that ends an interval keeps the polarity and
					// asks for the alternative frame instead.
					if (interval_end_in) begin
						nxt_alt = 1'h1;
					end else begin
						nxt_chop = ~chop_ff;
					end
				end
				MCB_CHOP_TOGGLE: begin
					nxt_chop = ~chop_ff;
				end
				default: begin
					nxt_chop = chop_ff;
				end
			endcase
		end
	end

	// Chop state registers.
	// The alternative frame request is a pulse of one cycle.
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync_d_ff <= 1'h0;
			chop_ff <= 1'h0;
			alt_ff <= 1'h0;
		end else begin
			sync_d_ff <= nxt_sync_d;
			chop_ff <= nxt_chop;
			alt_ff <= nxt_alt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Engine clock enable from a phase accumulator, since the system clock
	// is no whole multiple of the fast engine rate.

	logic [15:0] acc_ff;
	logic [15:0] nxt_acc;
	logic [15:0] acc_sum;
	logic tick_ff;
	logic nxt_tick;

	// Adds the selected rate each cycle and pulses on each wrap past the
	// system rate. The pulse spacing jitters by one system cycle at the fast
	// rate, but the average rate is exact. Clearing the enable also clears the
	// accumulator, so the first pulse after enabling comes at a fixed distance.
	always_comb begin
		acc_sum = acc_ff + (fld_ff.eng_clksel ? FAST_KHZ : SLOW_KHZ);
		nxt_acc = acc_sum;
		nxt_tick = 1'h0;
		if (!fld_ff.eng_en) begin
			nxt_acc = 16'h0000;
		end else if (acc_sum >= SYS_KHZ) begin
			nxt_acc = acc_sum - SYS_KHZ;
			nxt_tick = 1'h1;
		end
	end

	// Engine clock registers; reset leaves the engine clock stopped.
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_ff <= 16'h0000;
			tick_ff <= 1'h0;
		end else begin
			acc_ff <= nxt_acc;
			tick_ff <= nxt_tick;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registered control outputs.
	// Outputs change one cycle after the write edge that sets their field.

	logic [17:0] boot_end_ff;
	logic [17:0] nxt_boot_end;
	logic [14:0] prog_start_ff;
	logic [14:0] nxt_prog_start;
	logic [4:0] ctl_ff;
	logic [4:0] nxt_ctl;

	// Derived addresses and gated enables. The battery load and its route to
	// the converter switch together; the multiplexer decides in which frames
	// the battery is actually sampled.
	always_comb begin
		nxt_boot_end = {fld_ff.boot_size, 10'h000};
		nxt_prog_start = {fld_ff.prog_base, 10'h000};
		nxt_ctl[0] = fld_ff.conv_en;
		nxt_ctl[1] = fld_ff.batt_en;
		nxt_ctl[2] = fld_ff.eng_en;
		nxt_ctl[3] = fld_ff.imaster & fld_ff.ichan_a;
		nxt_ctl[4] = fld_ff.imaster & fld_ff.ichan_b;
	end

	// Output registers.
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			boot_end_ff <= {RST_FLD.boot_size, 10'h000};
			prog_start_ff <= {RST_FLD.prog_base, 10'h000};
			ctl_ff <= 5'h00;
		end else begin
			boot_end_ff <= nxt_boot_end;
			prog_start_ff <= nxt_prog_start;
			ctl_ff <= nxt_ctl;
		end
	end

	// Every output comes straight from a register.
	assign rdata_out = rdata_ff;
	assign conv_en_out = ctl_ff[0];
	assign batt_load_out = ctl_ff[1];
	assign batt_route_out = ctl_ff[1];
	assign eng_en_out = ctl_ff[2];
	assign ichop_a_out = ctl_ff[3];
	assign ichop_b_out = ctl_ff[4];
	assign boot_end_out = boot_end_ff;
	assign prog_start_out = prog_start_ff;
	assign eng_clk_en_out = tick_ff;
	assign chop_out = chop_ff;
	assign alt_frame_out = alt_ff;
endmodule : mcb_bank

// ===== rtl/mcb_cfg.svh
/*
 * Offsets, field positions, reset and wake values and clock figures
 * of the meter configuration bank.
 * Assumes byte-wide processor accesses on a 16-bit address.
 */
`ifndef MCB_CFG_SVH
`define MCB_CFG_SVH
`define MCB_ADDR_ENGINE 16'h2000
`define MCB_ADDR_BGCHOP 16'h2002
`define MCB_ADDR_CONV 16'h2005
`define MCB_ADDR_BATT 16'h2020
`define MCB_ADDR_BOOT 16'h20a7
`define MCB_ADDR_PROG 16'h20a8
`define MCB_ADDR_IMASTER 16'h20ab
`define MCB_ADDR_ICHAN 16'h20ac
`define MCB_BIT_ENG_CLKSEL 3
`define MCB_BIT_ENG_EN 4
`define MCB_BIT_BGCHOP_LO 4
`define MCB_BIT_CONV_EN 3
`define MCB_BIT_BATT_EN 6
`define MCB_BIT_IMASTER 0
`define MCB_BIT_ICHAN_A 0
`define MCB_BIT_ICHAN_B 4
`define MCB_RST_BOOT 8'h01
`define MCB_WAKE_BOOT 8'h01
`define MCB_RST_PROG 5'h1f
`define MCB_WAKE_PROG 5'h1f
`define MCB_RST_BIT 1'h0
`define MCB_WAKE_BIT 1'h0
`define MCB_RST_BGCHOP 2'h0
`define MCB_WAKE_BGCHOP 2'h0
`define MCB_WO_MASK 8'h00
`define MCB_UNIT_SHIFT 10
`define MCB_SYS_CLK_KHZ 25000
`define MCB_ENG_FAST_KHZ 10000
`define MCB_ENG_SLOW_KHZ 5000
`endif

// ===== rtl/mcb_pkg.sv
/*
 * Types of the meter configuration bank.
 * Assumes mcb_cfg.svh is on the include path.
 */
package mcb_pkg;
	// Bandgap chop modes.
	typedef enum logic [1:0] {
		MCB_CHOP_TOGGLE_ALT = 2'h0,
		MCB_CHOP_POSITIVE = 2'h1,
		MCB_CHOP_REVERSED = 2'h2,
		MCB_CHOP_TOGGLE = 2'h3
	} mcb_chop_mode_t;

	// One processor access to the I/O space.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mcb_bus_req_t;

	// All stored fields.
	typedef struct packed {
		logic eng_clksel;
		logic eng_en;
		mcb_chop_mode_t bgchop;
		logic conv_en;
		logic batt_en;
		logic [7:0] boot_size;
		logic [4:0] prog_base;
		logic imaster;
		logic ichan_a;
		logic ichan_b;
	} mcb_fields_t;
endpackage : mcb_pkg
